// ===== mmsd_pkg.sv
// package for the memory map and stack decode block
package mmsd_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;
    localparam logic [15:0] IO_LO          = 16'h0000;
    localparam logic [15:0] IO_HI          = 16'h003F;
    localparam logic [15:0] RAM_LO         = 16'h0050;
    localparam logic [15:0] RAM_HI         = 16'h018F;
    localparam logic [15:0] STK_LO         = 16'h00C0;
    localparam logic [15:0] STK_HI         = 16'h00FF;
    localparam logic [15:0] VEC_LO         = 16'hFFF0;
    localparam logic [15:0] VEC_RESET      = 16'hFFFE;
    localparam logic [15:0] VEC_SWI        = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ        = 16'hFFF8;
    localparam logic [2:0]  INT_FRAME      = 3'h5;
    localparam logic [2:0]  CALL_FRAME     = 3'h2;
    localparam logic [2:0]  ZERO_CNT       = 3'h0;
    localparam logic [2:0]  ONE_CNT        = 3'h1;
    localparam logic [15:0] NO_ADDR        = 16'h0000;

    // stack operation requested by the cpu core
    typedef enum logic [2:0] {
        MMSD_OP_NONE = 3'h0,
        MMSD_OP_PUSH = 3'h1,
        MMSD_OP_PULL = 3'h2,
        MMSD_OP_INT  = 3'h3,
        MMSD_OP_CALL = 3'h4,
        MMSD_OP_RTS  = 3'h5,
        MMSD_OP_RSP  = 3'h6
    } mmsd_op_t;

    typedef enum logic [1:0] {
        MMSD_ST_IDLE = 2'b00,
        MMSD_ST_PUSH = 2'b01,
        MMSD_ST_PULL = 2'b10
    } mmsd_st_t;

    typedef enum logic [2:0] {
        MMSD_VEC_NONE  = 3'h0,
        MMSD_VEC_IRQ   = 3'h1,
        MMSD_VEC_SWI   = 3'h2,
        MMSD_VEC_RESET = 3'h3,
        MMSD_VEC_OTHER = 3'h4
    } mmsd_vec_t;

    // region selects; stack sits inside ram
    typedef struct packed {
        logic io;
        logic ram;
        logic stack;
        logic vector;
        logic other;
    } mmsd_sel_t;
endpackage

// ===== mmsd_top.sv
// memory map decode and hardware stack pointer
// ------------------------------------------------------------
// Functional notes
// R1: flat 64K byte space; registers reached by ordinary load and store.
// R2: addresses 0000 to 003F select the i/o registers.
// R3: addresses 0050 to 018F select general ram.
// R4: stack lives in 00C0 to 00FF; every push and pull stays there.
// R5: interrupt entry pushes exactly five bytes.
// R6: call pushes two return bytes; return pulls two.
// R7: pointer decrements per push, increments per pull.
// R8: push below 00C0 wraps pointer to 00FF.
// R9: top addresses hold two-byte irq, swi and reset vectors.
// ------------------------------------------------------------
`timescale 1ns/1ps
module mmsd_top
    import mmsd_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    input  wire logic              ACC_VALID,
    input  wire logic [ADDR_W-1:0] ACC_ADDR,
    input  wire mmsd_op_t          STK_OP,
    output mmsd_sel_t              SEL,
    output logic [ADDR_W-1:0]      DEC_ADDR,
    output mmsd_vec_t              VEC_KIND,
    output logic [ADDR_W-1:0]      STK_ADDR,
    output logic                   STK_WR,
    output logic                   STK_RD,
    output logic                   STK_BUSY,
    output logic [ADDR_W-1:0]      SP
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic mmsd_sel_t decode(input logic [ADDR_W-1:0] a);
        mmsd_sel_t s;
        s        = '0;
        s.io     = (a <= IO_HI);                               // [R2]
        s.ram    = (a >= RAM_LO) && (a <= RAM_HI);              // [R3]
        s.stack  = (a >= STK_LO) && (a <= STK_HI);              // [R4]
        s.vector = (a >= VEC_LO);                               // [R9]
        s.other  = !(s.io || s.ram || s.vector);                // [R1]
        return s;
    endfunction

    function automatic mmsd_vec_t vec_of(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] e;
        e = {a[ADDR_W-1:1], 1'b0};
        if (a < VEC_LO) return MMSD_VEC_NONE;
        else if (e == VEC_RESET) return MMSD_VEC_RESET;        // [R9]
        else if (e == VEC_SWI) return MMSD_VEC_SWI;
        else if (e == VEC_IRQ) return MMSD_VEC_IRQ;
        else return MMSD_VEC_OTHER;
    endfunction

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SEL      <= '0;
            DEC_ADDR <= NO_ADDR;
            VEC_KIND <= MMSD_VEC_NONE;
        end else if (ACC_VALID) begin
            SEL      <= decode(ACC_ADDR);                        // [R1]
            DEC_ADDR <= ACC_ADDR;
            VEC_KIND <= vec_of(ACC_ADDR);
        end else begin
            SEL      <= '0;
            VEC_KIND <= MMSD_VEC_NONE;
        end
    end

    // ------------------------------------------------------------
    // stack sequencer
    // ------------------------------------------------------------
    mmsd_st_t   st_q;
    logic [2:0] cnt_q;
    wire        start = (st_q == MMSD_ST_IDLE) && (STK_OP != MMSD_OP_NONE);

    function automatic logic [ADDR_W-1:0] sp_dec(input logic [ADDR_W-1:0] p);
        return (p == STK_LO) ? STK_HI : p - 16'h0001;           // [R8]
    endfunction
    function automatic logic [ADDR_W-1:0] sp_inc(input logic [ADDR_W-1:0] p);
        return (p == STK_HI) ? STK_LO : p + 16'h0001;           // [R4]
    endfunction

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q  <= MMSD_ST_IDLE;
            cnt_q <= ZERO_CNT;
        end else begin
            unique case (st_q)
                MMSD_ST_IDLE: begin
                    unique case (STK_OP)
                        MMSD_OP_PUSH: begin st_q <= MMSD_ST_PUSH; cnt_q <= ONE_CNT;    end
                        MMSD_OP_INT:  begin st_q <= MMSD_ST_PUSH; cnt_q <= INT_FRAME;  end // [R5]
                        MMSD_OP_CALL: begin st_q <= MMSD_ST_PUSH; cnt_q <= CALL_FRAME; end // [R6]
                        MMSD_OP_PULL: begin st_q <= MMSD_ST_PULL; cnt_q <= ONE_CNT;    end
                        MMSD_OP_RTS:  begin st_q <= MMSD_ST_PULL; cnt_q <= CALL_FRAME; end // [R6]
                        default:      begin st_q <= MMSD_ST_IDLE; cnt_q <= ZERO_CNT;   end
                    endcase
                end
                MMSD_ST_PUSH, MMSD_ST_PULL: begin
                    cnt_q <= cnt_q - ONE_CNT;
                    if (cnt_q == ONE_CNT) st_q <= MMSD_ST_IDLE;
                end
                default: st_q <= MMSD_ST_IDLE;
            endcase
        end
    end

    // pointer: push writes at sp then decrements, pull increments then reads
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SP       <= STK_HI;
            STK_ADDR <= STK_HI;
            STK_WR   <= 1'b0;
            STK_RD   <= 1'b0;
        end else begin
            STK_WR <= 1'b0;
            STK_RD <= 1'b0;
            if (start && STK_OP == MMSD_OP_RSP) begin
                SP <= STK_HI;
            end else if (st_q == MMSD_ST_PUSH) begin
                STK_ADDR <= SP;
                STK_WR   <= 1'b1;
                SP       <= sp_dec(SP);                         // [R7] [R8]
            end else if (st_q == MMSD_ST_PULL) begin
                STK_ADDR <= sp_inc(SP);
                STK_RD   <= 1'b1;
                SP       <= sp_inc(SP);                         // [R7]
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) STK_BUSY <= 1'b0;
        else STK_BUSY <= (start && STK_OP != MMSD_OP_RSP) || (st_q != MMSD_ST_IDLE && cnt_q != ONE_CNT);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_io_sel;
        @(posedge REF_CLK) disable iff (!RST_N)
        ACC_VALID && ACC_ADDR <= IO_HI |=> SEL.io && !SEL.ram;
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("io decode wrong"); // [R2]

    property p_ram_sel;
        @(posedge REF_CLK) disable iff (!RST_N)
        ACC_VALID |=> SEL.ram == (DEC_ADDR >= RAM_LO && DEC_ADDR <= RAM_HI);
    endproperty
    a_ram_sel: assert property (p_ram_sel) else $error("ram decode wrong"); // [R3]

    property p_flat;
        @(posedge REF_CLK) disable iff (!RST_N)
        ACC_VALID |=> $onehot0({SEL.io, SEL.ram, SEL.vector}) && (SEL.io || SEL.ram || SEL.vector || SEL.other);
    endproperty
    a_flat: assert property (p_flat) else $error("address left unmapped"); // [R1]

    property p_in_stack;
        @(posedge REF_CLK) disable iff (!RST_N)
        STK_WR || STK_RD |-> STK_ADDR >= STK_LO && STK_ADDR <= STK_HI;
    endproperty
    a_in_stack: assert property (p_in_stack) else $error("stack access out of range"); // [R4]

    property p_int_five;
        @(posedge REF_CLK) disable iff (!RST_N)
        start && STK_OP == MMSD_OP_INT |=> ##1 STK_WR [*5] ##1 !STK_WR;
    endproperty
    a_int_five: assert property (p_int_five) else $error("interrupt frame not five bytes"); // [R5]

    property p_call_two;
        @(posedge REF_CLK) disable iff (!RST_N)
        start && STK_OP == MMSD_OP_CALL |=> ##1 STK_WR [*2] ##1 !STK_WR;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call frame not two bytes"); // [R6]

    property p_rts_two;
        @(posedge REF_CLK) disable iff (!RST_N)
        start && STK_OP == MMSD_OP_RTS |=> ##1 STK_RD [*2] ##1 !STK_RD;
    endproperty
    a_rts_two: assert property (p_rts_two) else $error("return not two bytes"); // [R6]

    property p_dir;
        @(posedge REF_CLK) disable iff (!RST_N)
        STK_WR && $past(SP) != STK_LO |-> SP == $past(SP) - 16'h0001;
    endproperty
    a_dir: assert property (p_dir) else $error("push did not decrement"); // [R7]

    property p_wrap;
        @(posedge REF_CLK) disable iff (!RST_N)
        STK_WR && STK_ADDR == STK_LO |-> SP == STK_HI;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // [R8]

    property p_vec;
        @(posedge REF_CLK) disable iff (!RST_N)
        ACC_VALID && ACC_ADDR[ADDR_W-1:1] == VEC_RESET[ADDR_W-1:1] |=> VEC_KIND == MMSD_VEC_RESET;
    endproperty
    a_vec: assert property (p_vec) else $error("reset vector not flagged"); // [R9]

    property p_pull_inc;
        @(posedge REF_CLK) disable iff (!RST_N)
        STK_RD && $past(SP) != STK_HI |-> SP == $past(SP) + 16'h0001;
    endproperty
    a_pull_inc: assert property (p_pull_inc) else $error("pull did not increment"); // [R7]

    property p_rsp;
        @(posedge REF_CLK) disable iff (!RST_N)
        start && STK_OP == MMSD_OP_RSP |=> SP == STK_HI && !STK_BUSY;
    endproperty
    a_rsp: assert property (p_rsp) else $error("pointer reload wrong"); // [R4]

    property p_one_dir;
        @(posedge REF_CLK) disable iff (!RST_N)
        STK_WR |-> !STK_RD;
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("push and pull together"); // [R7]

    c_int: cover property (@(posedge REF_CLK) disable iff (!RST_N) start && STK_OP == MMSD_OP_INT);
    c_call: cover property (@(posedge REF_CLK) disable iff (!RST_N) start && STK_OP == MMSD_OP_CALL);
    c_pull_wrap: cover property (@(posedge REF_CLK) disable iff (!RST_N) STK_RD && STK_ADDR == STK_LO);
    c_wrap: cover property (@(posedge REF_CLK) disable iff (!RST_N) STK_WR && STK_ADDR == STK_LO);
    c_rts: cover property (@(posedge REF_CLK) disable iff (!RST_N) start && STK_OP == MMSD_OP_RTS);
endmodule

// ===== mmsd_cpu_model.sv
// cpu core model issuing decode accesses and stack requests
`timescale 1ns/1ps
module mmsd_cpu_model
    import mmsd_pkg::*;
(
    input  wire logic         clk,
    output logic              acc_valid,
    output logic [ADDR_W-1:0] acc_addr,
    output mmsd_op_t          stk_op
);
    initial begin
        acc_valid = 1'b0;
        acc_addr  = NO_ADDR;
        stk_op    = MMSD_OP_NONE;
    end

    task automatic acc(input logic v, input logic [ADDR_W-1:0] a);
        @(posedge clk);
        acc_valid <= v;
        acc_addr  <= a;
    endtask

    // one-cycle request, then back to none
    task automatic issue(input mmsd_op_t op);
        @(posedge clk);
        stk_op <= op;
        @(posedge clk);
        stk_op <= MMSD_OP_NONE;
    endtask
endmodule

// ===== tb_memory_map_stack_decode.sv
// self-checking bench for the memory map and stack decode block
`timescale 1ns/1ps
module tb_memory_map_stack_decode;
    import mmsd_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              acc_valid;
    logic [15:0]       acc_addr;
    mmsd_op_t          stk_op;
    mmsd_sel_t         sel;
    mmsd_vec_t         vec_kind;
    logic [15:0]       dec_addr;
    logic [15:0]       stk_addr;
    logic [15:0]       sp;
    logic              stk_wr;
    logic              stk_rd;
    logic              stk_busy;
    logic [15:0]       sp_exp;
    int                bad_count = 0;
    int                samples_checked = 0;
    logic [15:0]       crn [0:16] = '{16'h0000, 16'h003F, 16'h0040, 16'h004F, 16'h0050, 16'h00BF, 16'h00C0,
        16'h00FF, 16'h0100, 16'h018F, 16'h0190, 16'hFFF7, 16'hFFF8, 16'hFFFB, 16'hFFFC, 16'hFFFE, 16'hFFFF};
    mmsd_op_t          ops [0:4] = '{MMSD_OP_PUSH, MMSD_OP_PULL, MMSD_OP_INT, MMSD_OP_CALL, MMSD_OP_RTS};

    always #2.5 clk = ~clk;

    mmsd_cpu_model i_cpu (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr), .stk_op(stk_op));

    mmsd_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .STK_OP(stk_op),
        .SEL(sel), .DEC_ADDR(dec_addr), .VEC_KIND(vec_kind), .STK_ADDR(stk_addr), .STK_WR(stk_wr),
        .STK_RD(stk_rd), .STK_BUSY(stk_busy), .SP(sp));

    // ------------------------------------------------------------
    // expectations and checking
    // ------------------------------------------------------------
    function automatic mmsd_sel_t f_sel(logic [15:0] a);
        f_sel.io     = (a <= IO_HI);
        f_sel.stack  = (a >= STK_LO) && (a <= STK_HI);
        f_sel.ram    = (a >= RAM_LO) && (a <= RAM_HI);
        f_sel.vector = (a >= VEC_LO);
        f_sel.other  = !(f_sel.io || f_sel.stack || f_sel.ram || f_sel.vector);
    endfunction

    function automatic mmsd_vec_t f_vec(logic [15:0] a);
        if (a < VEC_LO) return MMSD_VEC_NONE;
        case (a[3:1])
            3'h4: return MMSD_VEC_IRQ;
            3'h6: return MMSD_VEC_SWI;
            3'h7: return MMSD_VEC_RESET;
            default: return MMSD_VEC_OTHER;
        endcase
    endfunction

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // pipelined back-to-back accesses, result checked one cycle later
    task automatic t_dec(int n);
        logic [15:0] a;
        logic [15:0] pa;
        logic        v;
        logic        pv;
        pv = 1'b0;
        pa = NO_ADDR;
        for (int i = 0; i <= n; i++) begin
            a = (i < 17) ? crn[i] : 16'($urandom);
            v = (i < 17) || (i == n) ? (i < 17) : ($urandom % 5 != 0);
            i_cpu.acc(v, a);
            #1;
            if (i > 0) begin
                chk("sel", 16'(sel), pv ? 16'(f_sel(pa)) : 16'h0000);
                chk("vec", 16'(vec_kind), pv ? 16'(f_vec(pa)) : 16'h0000);
                if (pv) chk("dec_addr", dec_addr, pa);
            end
            pa = a;
            pv = v;
        end
        $display("decode test done");
    endtask

    task automatic t_op(mmsd_op_t op);
        int n;
        int cnt;
        logic wr;
        n   = (op == MMSD_OP_INT) ? 5 : (op == MMSD_OP_CALL || op == MMSD_OP_RTS) ? 2 : (op == MMSD_OP_RSP) ? 0 : 1;
        wr  = (op == MMSD_OP_PUSH || op == MMSD_OP_INT || op == MMSD_OP_CALL);
        cnt = 0;
        if (op == MMSD_OP_RSP) sp_exp = STK_HI;
        i_cpu.issue(op);
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            #1;
            if (stk_wr === 1'b1 || stk_rd === 1'b1) begin
                chk("stk_wr", 16'(stk_wr), 16'(wr));
                chk("stk_rd", 16'(stk_rd), 16'(!wr));
                if (!wr) sp_exp = (sp_exp == STK_HI) ? STK_LO : sp_exp + 16'h0001;
                chk("stk_addr", stk_addr, sp_exp);
                if (wr) sp_exp = (sp_exp == STK_LO) ? STK_HI : sp_exp - 16'h0001;
                cnt++;
                chk("stk_busy", 16'(stk_busy), 16'(cnt < n));
            end
            if (cnt >= n && stk_busy === 1'b0) break;
            if (k == 11) chk("busy_timeout", 16'(stk_busy), 16'h0000);
        end
        chk("strobes", 16'(cnt), 16'(n));
        chk("sp", sp, sp_exp);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(19));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("sp_reset", sp, STK_HI);
        chk("sel_reset", 16'(sel), 16'h0000);
        t_dec(80);
        t_op(MMSD_OP_RSP);
        repeat (13) t_op(MMSD_OP_INT);
        t_op(MMSD_OP_CALL);
        t_op(MMSD_OP_RTS);
        t_op(MMSD_OP_RSP);
        t_op(MMSD_OP_PULL);
        repeat (40) t_op(ops[$urandom % 5]);
        $display("stack test done");
        end_sim();
    end
endmodule
